// ---- shared/cmaddr_map.vh ----
// constants for the core memory addressing block
`ifndef CMADDR_MAP_VH
`define CMADDR_MAP_VH
`define CMADDR_PC_W          15
`define CMADDR_PROG_WORDS    16384
`define CMADDR_PROG_LAST     15'h3FFF
`define CMADDR_RESET_VEC     15'h0000
`define CMADDR_IRQ_VEC       15'h0004
`define CMADDR_STACK_DEPTH   16
`define CMADDR_STACK_PTR_W   5
`define CMADDR_PTR_W         16
`define CMADDR_DATA_W        8
`define CMADDR_INDF0_ADDR    16'h0000
`define CMADDR_INDF1_ADDR    16'h0001
`define CMADDR_LIN_BASE      16'h2000
`define CMADDR_FLASH_BASE    16'h8000
`define CMADDR_REGION_TRAD   2'h0
`define CMADDR_REGION_LIN    2'h1
`define CMADDR_REGION_FLASH  2'h2
`endif

// ---- verilog/cmaddr_fsr_chan.v ----
// one indirect access channel: pointer pair, region decode and port redirection
`include "cmaddr_map.vh"
module cmaddr_fsr_chan #(
  parameter [15:0] LIN_BASE   = `CMADDR_LIN_BASE,
  parameter [15:0] FLASH_BASE = `CMADDR_FLASH_BASE
) (
  // clock, reset and enable
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // pointer byte writes
  input  wire        i_wr_high,
  input  wire        i_wr_low,
  input  wire [7:0]  i_wdata,
  // indirect access through the data port
  input  wire        i_acc_rd,
  input  wire        i_acc_wr,
  // results
  output wire [15:0] o_ptr,
  output wire [1:0]  o_region,
  output wire        o_self,
  output wire        o_mem_rd,
  output wire        o_mem_wr
);
  reg [7:0] pointer_high_byte_reg;
  reg [7:0] pointer_low_byte_reg;

  function [1:0] region_of;
    input [15:0] a;
    begin
      if (a >= FLASH_BASE)
        region_of = `CMADDR_REGION_FLASH;
      else if (a >= LIN_BASE)
        region_of = `CMADDR_REGION_LIN;
      else
        region_of = `CMADDR_REGION_TRAD;
    end
  endfunction

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pointer_high_byte_reg <= 8'h00;
      pointer_low_byte_reg  <= 8'h00;
    end else if (i_ce) begin
      if (i_wr_high)
        pointer_high_byte_reg <= i_wdata;
      if (i_wr_low)
        pointer_low_byte_reg  <= i_wdata;
    end
  end

  assign o_ptr    = {pointer_high_byte_reg, pointer_low_byte_reg};
  assign o_region = region_of(o_ptr);
  assign o_self   = (o_ptr == `CMADDR_INDF0_ADDR) || (o_ptr == `CMADDR_INDF1_ADDR);
  assign o_mem_rd = i_acc_rd & ~o_self;
  assign o_mem_wr = i_acc_wr & ~o_self;
endmodule // cmaddr_fsr_chan

// ---- verilog/cmaddr_core.v ----
// core memory addressing: program counter, stack fault reset, indirect addressing
`include "cmaddr_map.vh"
// Notes on behaviour
// - the program counter is fifteen bits wide, spanning a 32K word space.
// - 16384 words are implemented up to 3FFFh and higher addresses wrap into them.
// - after any reset the program counter is zero and fetch starts there.
// - a taken interrupt sends the program counter to address four.
// - with stack fault reset enabled, a push past level sixteen resets and sets the overflow flag.
// - with stack fault reset enabled, a pop past level one resets and sets the underflow flag.
// - the indirect data ports hold nothing; accesses go to the address in their pointer.
// - a pointer aimed at a data port reads zero and suppresses the write.
// - there are two channels, each with its own port and pointer; channel 0 wins when both access in one cycle.
// - each pointer is a high byte and a low byte that software writes separately.
// - the pointer is a 16-bit address over 65536 locations in three regions.
module cmaddr_core #(
  parameter [15:0] LIN_BASE   = `CMADDR_LIN_BASE,
  parameter [15:0] FLASH_BASE = `CMADDR_FLASH_BASE,
  parameter        DEPTH      = `CMADDR_STACK_DEPTH
) (
  // clock, reset, enable
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // configuration
  input  wire        i_stack_fault_reset_enable,
  // program flow from the core
  input  wire        i_pc_step,
  input  wire        i_pc_load,
  input  wire [14:0] i_pc_target,
  input  wire        i_irq_take,
  input  wire        i_push,
  input  wire        i_pop,
  input  wire        i_flags_clr,
  // pointer writes, channel 0 and 1
  input  wire [1:0]  i_wr_high,
  input  wire [1:0]  i_wr_low,
  input  wire [7:0]  i_wdata,
  // indirect accesses, channel 0 and 1
  input  wire [1:0]  i_acc_rd,
  input  wire [1:0]  i_acc_wr,
  input  wire [7:0]  i_acc_wdata,
  input  wire [7:0]  i_mem_rdata,
  // program counter and stack
  output reg  [14:0] o_pc,
  output reg  [13:0] o_fetch_addr,
  output reg  [14:0] o_stack_top,
  output reg         o_stack_fault_reset,
  output reg         o_stack_overflow_flag,
  output reg         o_stack_underflow_flag,
  // memory access from the indirect channels
  output reg  [15:0] o_mem_addr,
  output reg  [1:0]  o_mem_region,
  output reg         o_mem_rd,
  output reg         o_mem_wr,
  output reg  [7:0]  o_mem_wdata,
  output reg  [7:0]  o_acc_rdata,
  output reg         o_acc_rvalid
);
  reg  [14:0] stack_mem [0:DEPTH-1];
  reg  [4:0]  sp_reg;
  reg  [14:0] pc_reg;
  reg         pend_rd_reg;
  reg         pend_self_reg;
  wire [31:0] ptr_bus;
  wire [3:0]  region_bus;
  wire [1:0]  self_v;
  wire [1:0]  mrd_v;
  wire [1:0]  mwr_v;
  wire        sel;
  wire        ovf;
  wire        unf;
  wire        fault;
  reg  [14:0] pc_next;
  integer     k;
  reg  [4:0]  sp_next;
  reg  [14:0] top_next;
  reg         push_ok;
  reg         pop_ok;
  reg         ovf_flag_next;
  reg         unf_flag_next;
  reg  [15:0] mem_addr_next;
  reg  [1:0]  mem_region_next;
  reg         mem_rd_next;
  reg         mem_wr_next;
  reg         pend_rd_next;
  reg         pend_self_next;
  reg  [7:0]  acc_rdata_next;
  reg  [1:0]  pc_src;

  localparam [1:0] PC_SRC_HOLD = 2'b00;
  localparam [1:0] PC_SRC_STEP = 2'b01;
  localparam [1:0] PC_SRC_LOAD = 2'b10;
  localparam [1:0] PC_SRC_IRQ  = 2'b11;

  // fetch port view of the counter: the upper half aliases the implemented half
  function [13:0] fetch_of;
    input [14:0] a;
    begin
      fetch_of = a[13:0];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
      cmaddr_fsr_chan #(
        .LIN_BASE   (LIN_BASE),
        .FLASH_BASE (FLASH_BASE)
      ) u_chan (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_wr_high (i_wr_high[g]),
        .i_wr_low  (i_wr_low[g]),
        .i_wdata   (i_wdata),
        .i_acc_rd  (i_acc_rd[g]),
        .i_acc_wr  (i_acc_wr[g]),
        .o_ptr     (ptr_bus[16*g+15:16*g]),
        .o_region  (region_bus[2*g+1:2*g]),
        .o_self    (self_v[g]),
        .o_mem_rd  (mrd_v[g]),
        .o_mem_wr  (mwr_v[g])
      );
    end
  endgenerate

  // channel 1 used when it alone accesses; channel 0 has priority
  assign sel   = ~(i_acc_rd[0] | i_acc_wr[0]) & (i_acc_rd[1] | i_acc_wr[1]);
  assign ovf   = i_push & ~i_pop & (sp_reg == DEPTH[4:0]);
  assign unf   = i_pop & ~i_push & (sp_reg == 5'h00);
  assign fault = i_stack_fault_reset_enable & (ovf | unf);

  // irq beats a load, a load beats a step
  always @* begin
    if (i_irq_take)
      pc_src = PC_SRC_IRQ;
    else if (i_pc_load)
      pc_src = PC_SRC_LOAD;
    else if (i_pc_step)
      pc_src = PC_SRC_STEP;
    else
      pc_src = PC_SRC_HOLD;
  end

  always @* begin
    case (pc_src)
      PC_SRC_IRQ: begin
        pc_next = `CMADDR_IRQ_VEC;
      end
      PC_SRC_LOAD: begin
        pc_next = i_pc_target;
      end
      PC_SRC_STEP: begin
        pc_next = pc_reg + 15'h0001;
      end
      default: begin
        pc_next = pc_reg;
      end
    endcase
  end

  // stack pointer and top-of-stack next values; push and pop together cancel
  always @* begin
    sp_next  = sp_reg;
    top_next = o_stack_top;
    push_ok  = 1'b0;
    pop_ok   = 1'b0;
    if (i_push && !i_pop && !ovf) begin
      push_ok  = 1'b1;
      sp_next  = sp_reg + 5'h01;
      top_next = pc_reg;
    end else if (i_pop && !i_push && !unf) begin
      pop_ok   = 1'b1;
      sp_next  = sp_reg - 5'h01;
      top_next = stack_mem[sp_reg[3:0] - 4'h1];
    end
  end

  // sticky flags: a fault in the same cycle as a clear still sets the flag
  always @* begin
    ovf_flag_next = o_stack_overflow_flag;
    unf_flag_next = o_stack_underflow_flag;
    if (i_flags_clr) begin
      ovf_flag_next = 1'b0;
      unf_flag_next = 1'b0;
    end
    if (i_stack_fault_reset_enable && ovf)
      ovf_flag_next = 1'b1;
    if (i_stack_fault_reset_enable && unf)
      unf_flag_next = 1'b1;
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pc_reg                 <= `CMADDR_RESET_VEC;
      sp_reg                 <= 5'h00;
      o_pc                   <= `CMADDR_RESET_VEC;
      o_fetch_addr           <= fetch_of(`CMADDR_RESET_VEC);
      o_stack_top            <= 15'h0000;
      o_stack_fault_reset    <= 1'b0;
      o_stack_overflow_flag  <= 1'b0;
      o_stack_underflow_flag <= 1'b0;
    end else if (i_ce) begin
      o_stack_fault_reset    <= fault;
      o_stack_overflow_flag  <= ovf_flag_next;
      o_stack_underflow_flag <= unf_flag_next;
      if (fault) begin
        // internal reset: vector to zero and empty the stack
        pc_reg       <= `CMADDR_RESET_VEC;
        sp_reg       <= 5'h00;
        o_pc         <= `CMADDR_RESET_VEC;
        o_fetch_addr <= fetch_of(`CMADDR_RESET_VEC);
      end else begin
        pc_reg       <= pc_next;
        o_pc         <= pc_next;
        o_fetch_addr <= fetch_of(pc_next);
        sp_reg       <= sp_next;
        o_stack_top  <= top_next;
      end
    end
  end

  // stack storage: one word per level, written only by a push that fits
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (k = 0; k < DEPTH; k = k + 1)
        stack_mem[k] <= 15'h0000;
    end else if (i_ce) begin
      if (!fault && push_ok)
        stack_mem[sp_reg[3:0]] <= pc_reg;
    end
  end

  // pick the channel that owns this cycle's access
  always @* begin
    if (sel) begin
      mem_addr_next   = ptr_bus[31:16];
      mem_region_next = region_bus[3:2];
      mem_rd_next     = mrd_v[1];
      mem_wr_next     = mwr_v[1];
      pend_rd_next    = i_acc_rd[1];
      pend_self_next  = self_v[1];
    end else begin
      mem_addr_next   = ptr_bus[15:0];
      mem_region_next = region_bus[1:0];
      mem_rd_next     = mrd_v[0];
      mem_wr_next     = mwr_v[0];
      pend_rd_next    = i_acc_rd[0];
      pend_self_next  = self_v[0];
    end
  end

  // a port aimed at a port reads as zero
  always @* begin
    if (pend_self_reg)
      acc_rdata_next = 8'h00;
    else
      acc_rdata_next = i_mem_rdata;
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_mem_addr    <= 16'h0000;
      o_mem_region  <= `CMADDR_REGION_TRAD;
      o_mem_rd      <= 1'b0;
      o_mem_wr      <= 1'b0;
      o_mem_wdata   <= 8'h00;
      o_acc_rdata   <= 8'h00;
      o_acc_rvalid  <= 1'b0;
      pend_rd_reg   <= 1'b0;
      pend_self_reg <= 1'b0;
    end else if (i_ce) begin
      o_mem_addr    <= mem_addr_next;
      o_mem_region  <= mem_region_next;
      o_mem_rd      <= mem_rd_next;
      o_mem_wr      <= mem_wr_next;
      o_mem_wdata   <= i_acc_wdata;
      pend_rd_reg   <= pend_rd_next;
      pend_self_reg <= pend_self_next;
      o_acc_rvalid  <= pend_rd_reg;
      o_acc_rdata   <= acc_rdata_next;
    end
  end
endmodule // cmaddr_core

// ---- tb/cmaddr_props.sv ----
// assertion checker for the core memory addressing block
module cmaddr_props #(
  parameter [15:0] LIN_BASE   = 16'h2000,
  parameter [15:0] FLASH_BASE = 16'h8000
) (
  // clock, reset, requests and read data
  input wire logic        i_clk_sys, i_rst_n, i_ce, i_stack_fault_reset_enable,
  input wire logic        i_pc_step, i_pc_load, i_irq_take, i_push, i_pop,
  input wire logic [1:0]  i_acc_rd,
  input wire logic [7:0]  i_mem_rdata, o_acc_rdata,
  // results
  input wire logic [14:0] o_pc,
  input wire logic [13:0] o_fetch_addr,
  input wire logic [15:0] o_mem_addr,
  input wire logic [1:0]  o_mem_region,
  input wire logic        o_stack_fault_reset, o_stack_overflow_flag, o_stack_underflow_flag,
  input wire logic        o_mem_rd, o_mem_wr, o_acc_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire quiet = !(i_pc_load | i_irq_take | i_push | i_pop);
  sequence s_fault; o_stack_fault_reset && o_pc == 15'h0000; endsequence
  sequence s_rd_req; i_ce && i_acc_rd != 2'b00 ##1 i_ce; endsequence
  property p_step; i_ce && i_pc_step && quiet |=> o_pc == $past(o_pc) + 15'h0001; endproperty
  a_step: assert property (p_step) else $error("pc step wrong");
  property p_fetch; o_fetch_addr == o_pc[13:0]; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");
  property p_rst; disable iff (1'b0) !i_rst_n |=> o_pc == 15'h0000 && !o_mem_rd; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_irq; i_ce && i_irq_take && !i_push && !i_pop |=> o_pc == 15'h0004; endproperty
  a_irq: assert property (p_irq) else $error("irq vector wrong");
  property p_fault;
    o_stack_fault_reset |-> s_fault ##0 $past(i_stack_fault_reset_enable)
      && $past(i_push) != $past(i_pop) ##1 !o_stack_fault_reset;
  endproperty
  a_fault: assert property (p_fault) else $error("stack fault reset wrong");
  property p_flag;
    o_stack_fault_reset |-> ($past(i_push) ? o_stack_overflow_flag : o_stack_underflow_flag);
  endproperty
  a_flag: assert property (p_flag) else $error("stack flag wrong");
  property p_acc; s_rd_req |-> (o_mem_rd || o_mem_addr <= 16'h0001) ##1 o_acc_rvalid; endproperty
  a_acc: assert property (p_acc) else $error("indirect read lost");
  property p_rdata;
    o_acc_rvalid && $past(i_ce) |->
      o_acc_rdata == ($past(o_mem_addr) <= 16'h0001 ? 8'h00 : $past(i_mem_rdata));
  endproperty
  a_rdata: assert property (p_rdata) else $error("indirect data wrong");
  property p_region;
    o_mem_rd || o_mem_wr |-> o_mem_addr > 16'h0001 && o_mem_region ==
      (o_mem_addr >= FLASH_BASE ? 2'h2 : o_mem_addr >= LIN_BASE ? 2'h1 : 2'h0);
  endproperty
  a_region: assert property (p_region) else $error("region wrong");
endmodule // cmaddr_props
bind cmaddr_core cmaddr_props #(.LIN_BASE(LIN_BASE), .FLASH_BASE(FLASH_BASE)) u_props (.*);

// ---- tb/cmaddr_mem_model.sv ----
// data memory answering the indirect accesses of the block
module cmaddr_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output wire logic [7:0]  o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic       idle_reg = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5A;
  // outside a read the lines change every cycle
  assign o_rdata = i_rd ? mem[i_addr[7:0]] : {8{idle_reg}} ^ 8'h3C;
  always @(posedge i_clk_sys) begin
    idle_reg <= ~idle_reg;
    if (i_wr) mem[i_addr[7:0]] <= i_wdata;
  end
endmodule // cmaddr_mem_model

// ---- tb/cmaddr_core_tb.sv ----
// self-checking bench for the core memory addressing block
module cmaddr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
  int          errors = 0, total_checks = 0;
  logic        i_clk_sys = 0, i_rst_n = 0, i_ce = 1, i_stack_fault_reset_enable = 1;
  logic        i_pc_step = 0, i_pc_load = 0, i_irq_take = 0, i_push = 0, i_pop = 0;
  logic        i_flags_clr = 0, o_stack_fault_reset, o_stack_overflow_flag;
  logic        o_stack_underflow_flag, o_mem_rd, o_mem_wr, o_acc_rvalid;
  logic [14:0] i_pc_target = 0, o_pc, o_stack_top;
  logic [1:0]  i_wr_high = 0, i_wr_low = 0, i_acc_rd = 0, i_acc_wr = 0, o_mem_region;
  logic [7:0]  i_wdata = 0, i_acc_wdata = 0, i_mem_rdata, o_mem_wdata, o_acc_rdata;
  logic [13:0] o_fetch_addr;
  logic [15:0] o_mem_addr, p;
  logic [7:0]  shadow [256];
  logic [15:0] corner [5] = '{16'h1FFF, 16'h2000, 16'h7FFF, 16'h8000, 16'h0002};
  cmaddr_core DUT (.*);
  cmaddr_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  initial forever #12.5 i_clk_sys = ~i_clk_sys;
  function automatic logic [1:0] region_of(logic [15:0] a);
    return a >= 16'h8000 ? 2'h2 : a >= 16'h2000 ? 2'h1 : 2'h0;
  endfunction
  task automatic cyc(int n = 1); repeat (n) @(negedge i_clk_sys); endtask
  task automatic pulse(ref logic s); s = 1; cyc(); s = 0; endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // the other channel gets the byte-swapped pointer at the same time
  task automatic acc(int ch, logic wr, logic [15:0] a, logic [7:0] d);
    logic at_port;
    at_port = a <= 16'h0001;
    i_wdata = a[15:8]; i_wr_high[ch] = 1; i_wr_low[ch^1] = 1; cyc();
    i_wr_high = 0; i_wr_low = 0; i_wdata = a[7:0]; i_wr_low[ch] = 1; i_wr_high[ch^1] = 1; cyc();
    i_wr_high = 0; i_wr_low = 0; i_acc_rd[ch] = !wr; i_acc_wr[ch] = wr; i_acc_wdata = d; cyc();
    i_acc_rd = 0; i_acc_wr = 0;
    `CHK("mem_strobe", {!at_port && !wr, !at_port && wr}, {o_mem_rd, o_mem_wr})
    if (!at_port) `CHK("mem_addr", {a, region_of(a)}, {o_mem_addr, o_mem_region})
    if (wr) `CHK("mem_wdata", d, o_mem_wdata)
    if (!at_port && wr) shadow[a[7:0]] = d;
    cyc();
    if (!wr) `CHK("acc_rdata", {1'b1, at_port ? 8'h00 : shadow[a[7:0]]},
      {o_acc_rvalid, o_acc_rdata})
  endtask
  initial begin
    void'($urandom(32'hCA04));
    foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'h5A;
    cyc(5);
    i_rst_n = 1;
    `CHK("pc_reset", 15'h0000, o_pc)
    pulse(i_irq_take);
    `CHK("pc_irq", 15'h0004, o_pc)
    i_ce = 0;
    pulse(i_pc_step);
    i_ce = 1;
    `CHK("pc_frozen", 15'h0004, o_pc)
    for (int k = 0; k < 12; k++) begin
      p = k < 2 ? 16'(16'h3FFF + k * 16'h4000) : 16'($urandom);
      i_pc_target = p[14:0];
      pulse(i_pc_load);
      pulse(i_pc_step);
      `CHK("pc_step", p[14:0] + 15'h0001, o_pc)
      `CHK("fetch_wrap", p[13:0] + 14'h0001, o_fetch_addr)
    end
    repeat (16) pulse(i_push);
    `CHK("stack_top", p[14:0] + 15'h0001, o_stack_top)
    `CHK("no_fault", 1'b0, o_stack_fault_reset)
    pulse(i_push);
    `CHK("ovf", {3'b110, 15'h0000}, {o_stack_fault_reset, o_stack_overflow_flag,
      o_stack_underflow_flag, o_pc})
    i_rst_n = 0;
    cyc();
    i_rst_n = 1;
    `CHK("rerst", 17'h00000, {o_stack_overflow_flag, o_stack_underflow_flag, o_pc})
    pulse(i_pop);
    `CHK("unf", 3'b101, {o_stack_fault_reset, o_stack_overflow_flag, o_stack_underflow_flag})
    pulse(i_flags_clr);
    i_stack_fault_reset_enable = 0;
    pulse(i_pop);
    `CHK("unf_off", 2'b00, {o_stack_fault_reset, o_stack_underflow_flag})
    acc(1, 0, 16'h0000, 8'h00);
    acc(0, 1, 16'h0001, 8'hA5);
    acc(0, 1, 16'h2040, 8'hC3);
    acc(1, 0, 16'h2040, 8'h00);
    for (int k = 0; k < 29; k++) acc(k % 2, k[2], k < 5 ? corner[k] : 16'($urandom), 8'($urandom));
    wrap_up;
  end
endmodule // cmaddr_core_tb
